/* File: logic/sse_pkg.sv */
// constants shared by the safe state engine design and its bench
// assumes a single 40 MHz clock domain and no software register bus
package sse_pkg;
   localparam int          SSE_CLK_HZ      = 40_000_000;
   localparam int          SSE_IN_W        = 8;
   localparam int          SSE_TMO_W       = 16;
   localparam int          SSE_LUT_IDX_W   = 3;
   localparam int          SSE_LUT_W       = 2 * (1 << SSE_LUT_IDX_W);
   // lut index bit positions
   localparam int          SSE_IDX_MATCH   = 2;
   localparam int          SSE_IDX_REG_TMO = 1;
   localparam int          SSE_IDX_PIN_TMO = 0;
   // unlock key, then reset values of the configuration and outputs
   localparam logic [15:0] SSE_UNLOCK_KEY  = 16'hC35A;
   localparam logic [15:0] SSE_LUT_RST     = 16'hFFFC;
   localparam logic [15:0] SSE_TMO_RST     = 16'h0000;
   localparam logic [1:0]  SSE_OUT_RST     = 2'h0;

   typedef enum logic [0:0] {
      SSE_OPEN   = 1'b0,
      SSE_LOCKED = 1'b1
   } sse_lock_t;
endpackage

/* File: logic/sse_engine.sv */
// safe state engine: compare, two watchdogs, lookup table to fault pins
// assumes all inputs synchronous to core_clk_in; config comes on plain ports
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - monitored value comes from input pins or the written input register
// - monitored value is compared against the reference compare register
// - watchdog flags an input register not rewritten within the timeout
// - watchdog flags a missing expected transition on watched input pins
// - two outputs come from a fully programmable lookup table
// - both table outputs drive pins and feed fault reporting
// - configuration is guarded against unintended writes
// - after configuration the engine runs with no software action
// - a locked configuration ignores every write until unlocked
module sse_engine #(
   parameter int W   = sse_pkg::SSE_IN_W,
   parameter int TMW = sse_pkg::SSE_TMO_W
) (
   input  wire logic                          core_clk_in,
   input  wire logic                          nrst_in,
   input  wire logic                          clk_en_in,
   input  wire logic [W-1:0]                  pin_in,
   input  wire logic                          in_wr_in,
   input  wire logic [W-1:0]                  in_wdata_in,
   input  wire logic                          cfg_wr_in,
   input  wire logic                          cfg_src_reg_in,
   input  wire logic [W-1:0]                  cfg_ref_in,
   input  wire logic [W-1:0]                  cfg_pin_watch_in,
   input  wire logic [TMW-1:0]                cfg_timeout_in,
   input  wire logic [sse_pkg::SSE_LUT_W-1:0] cfg_lut_in,
   input  wire logic                          lock_in,
   input  wire logic                          unlock_in,
   input  wire logic [15:0]                   unlock_key_in,
   output logic      [1:0]                    fault_pin_out,
   output logic      [1:0]                    fault_report_out,
   output logic                               match_out,
   output logic                               reg_stale_out,
   output logic                               pin_stale_out,
   output logic                               locked_out
);
   import sse_pkg::*;

   // next count of a watchdog timer; a zero timeout disables it
   // the count saturates at the timeout, so an unserviced input keeps its
   // flag without the timer wrapping round and raising it a second time
   // a timeout of one flags every cycle, since expiry wins over restart
   function automatic logic [TMW-1:0] tmo_next(
      input logic [TMW-1:0] cnt,
      input logic [TMW-1:0] tmo,
      input logic           restart
   );
      logic [TMW-1:0] res;
      res = cnt;
      if (restart || tmo == '0) begin
         res = '0;
      end else if (cnt != tmo) begin
         res = cnt + 1'b1;
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   // entry stays asynchronous so the fault pins clear at once; release is
   // synchronised so every flop leaves reset on the same edge
   logic rst_s1_r;
   logic rst_s2_r;
   logic rst_n;

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   ////////////////////////////////////////////////////////////////////////
   // configuration and lock
   sse_lock_t              lock_r,  lock_nxt;
   logic                   src_r,   src_nxt;
   logic [W-1:0]           ref_r,   ref_nxt;
   logic [W-1:0]           watch_r, watch_nxt;
   logic [TMW-1:0]         tmo_r,   tmo_nxt;
   logic [SSE_LUT_W-1:0]   lut_r,   lut_nxt;

   always_comb begin
      lock_nxt  = lock_r;
      src_nxt   = src_r;
      ref_nxt   = ref_r;
      watch_nxt = watch_r;
      tmo_nxt   = tmo_r;
      lut_nxt   = lut_r;
      case (lock_r)
         SSE_OPEN: begin
            // writes land only while open
            // a write and a lock in one cycle: the write lands, then it closes
            if (cfg_wr_in) begin
               src_nxt   = cfg_src_reg_in;
               ref_nxt   = cfg_ref_in;
               watch_nxt = cfg_pin_watch_in;
               tmo_nxt   = cfg_timeout_in;
               lut_nxt   = cfg_lut_in;
            end
            if (lock_in) begin
               lock_nxt = SSE_LOCKED;
            end
         end
         SSE_LOCKED: begin
            // every write dropped; only a keyed unlock or a reset reopens
            if (unlock_in && unlock_key_in == SSE_UNLOCK_KEY) begin
               lock_nxt = SSE_OPEN;
            end
         end
         default: lock_nxt = SSE_LOCKED;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         lock_r  <= SSE_OPEN;
         src_r   <= 1'b0;
         ref_r   <= '0;
         watch_r <= '0;
         tmo_r   <= TMW'(SSE_TMO_RST);
         lut_r   <= SSE_LUT_RST;
      end else if (clk_en_in) begin
         lock_r  <= lock_nxt;
         src_r   <= src_nxt;
         ref_r   <= ref_nxt;
         watch_r <= watch_nxt;
         tmo_r   <= tmo_nxt;
         lut_r   <= lut_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // monitoring: input register, compare, watchdogs, table
   // the input register is data, not configuration, so lock does not stop
   // it: software must keep servicing it while locked
   logic [W-1:0]            inreg_r,   inreg_nxt;
   logic [W-1:0]            pin_d_r,   pin_d_nxt;
   logic [TMW-1:0]          rcnt_r,    rcnt_nxt;
   logic [TMW-1:0]          pcnt_r,    pcnt_nxt;
   logic                    rstale_r,  rstale_nxt;
   logic                    pstale_r,  pstale_nxt;
   logic                    match_r,   match_nxt;
   logic [1:0]              fault_r,   fault_nxt;
   logic [W-1:0]            mon_val;
   logic                    pin_edge;
   logic                    r_exp;
   logic                    p_exp;
   logic                    cfg_load;
   logic [SSE_LUT_IDX_W-1:0] idx;

   always_comb begin
      inreg_nxt = in_wr_in ? in_wdata_in : inreg_r;
      // history resets low; pins idle high after reset only restart the
      // pin timer once, which cannot raise a false flag
      pin_d_nxt = pin_in;
      // source select
      mon_val   = src_r ? inreg_r : pin_in;
      match_nxt = (mon_val == ref_r);
      pin_edge  = |((pin_in ^ pin_d_r) & watch_r);
      // timers restart on service
      // an accepted config write restarts them too: a count left above a
      // newly lowered timeout would otherwise run on until it wrapped
      cfg_load  = cfg_wr_in && (lock_r == SSE_OPEN);
      rcnt_nxt  = tmo_next(rcnt_r, tmo_r, in_wr_in || !src_r || cfg_load);
      pcnt_nxt  = tmo_next(pcnt_r, tmo_r,
                           pin_edge || watch_r == '0 || cfg_load);
      r_exp     = src_r && tmo_r != '0 && rcnt_r == tmo_r - 1'b1;
      p_exp     = watch_r != '0 && tmo_r != '0 && pcnt_r == tmo_r - 1'b1;
      // expiry wins over a restart in the same cycle
      rstale_nxt = r_exp ? 1'b1 : (in_wr_in ? 1'b0 : rstale_r);
      pstale_nxt = p_exp ? 1'b1 : (pin_edge ? 1'b0 : pstale_r);
      if (!src_r) begin
         rstale_nxt = 1'b0;
      end
      if (watch_r == '0) begin
         pstale_nxt = 1'b0;
      end
      idx = '0;
      idx[SSE_IDX_MATCH]   = match_r;
      idx[SSE_IDX_REG_TMO] = rstale_r;
      idx[SSE_IDX_PIN_TMO] = pstale_r;
      fault_nxt = lut_r[2*idx +: 2];
   end

   // free-running evaluation, no software needed once set up
   always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         inreg_r  <= '0;
         pin_d_r  <= '0;
         rcnt_r   <= '0;
         pcnt_r   <= '0;
         rstale_r <= 1'b0;
         pstale_r <= 1'b0;
         match_r  <= 1'b0;
         fault_r  <= SSE_OUT_RST;
      end else if (clk_en_in) begin
         inreg_r  <= inreg_nxt;
         pin_d_r  <= pin_d_nxt;
         rcnt_r   <= rcnt_nxt;
         pcnt_r   <= pcnt_nxt;
         rstale_r <= rstale_nxt;
         pstale_r <= pstale_nxt;
         match_r  <= match_nxt;
         fault_r  <= fault_nxt;
      end
   end

   assign fault_pin_out    = fault_r;
   assign fault_report_out = fault_r;
   assign match_out        = match_r;
   assign reg_stale_out    = rstale_r;
   assign pin_stale_out    = pstale_r;
   assign locked_out       = (lock_r == SSE_LOCKED);
endmodule // sse_engine

`default_nettype wire

/* File: verification/sse_fault_mon.sv */
// far-side model: fault monitor that watches the two fault pins
// assumes the pins are synchronous to the engine clock
`timescale 1ns/1ps
`default_nettype none
module sse_fault_mon (
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic [1:0] fault_in,
   output logic      [1:0] latched_out
);
   logic [1:0] last_r;
   // two equal samples before latching, so a glitch is not taken as a fault
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         last_r      <= 2'h0;
         latched_out <= 2'h0;
      end else begin
         last_r      <= fault_in;
         latched_out <= latched_out | (last_r & fault_in);
      end
   end
endmodule // sse_fault_mon
`default_nettype wire

/* File: verification/sse_engine_asserts.sv */
// port checker for the safe state engine
// assumes the bind below and the default widths
`timescale 1ns/1ps
`default_nettype none
module sse_engine_asserts
   import sse_pkg::*;
(
   input wire logic        core_clk_in,
   input wire logic        nrst_in,
   input wire logic        clk_en_in,
   input wire logic        in_wr_in,
   input wire logic        cfg_wr_in,
   input wire logic        lock_in,
   input wire logic        unlock_in,
   input wire logic [15:0] unlock_key_in,
   input wire logic [1:0]  fault_pin_out,
   input wire logic [1:0]  fault_report_out,
   input wire logic        reg_stale_out,
   input wire logic        locked_out
);
   logic svc;
   assign svc = in_wr_in || cfg_wr_in;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_unl;
      clk_en_in && unlock_in && unlock_key_in == SSE_UNLOCK_KEY;
   endsequence
   property p_twin; fault_pin_out == fault_report_out; endproperty
   a_twin: assert property (p_twin) else $error("copies differ");
   property p_lock; clk_en_in && lock_in && !unlock_in |=> locked_out;
   endproperty
   a_lock: assert property (p_lock) else $error("no lock");
   property p_hold; locked_out && !(unlock_in && unlock_key_in ==
      SSE_UNLOCK_KEY) |=> locked_out; endproperty
   a_hold: assert property (p_hold) else $error("lock lost");
   property p_unl; locked_out && !lock_in ##0 s_unl |=> !locked_out;
   endproperty
   a_unl: assert property (p_unl) else $error("no unlock");
   property p_frz; !clk_en_in |=>
      $stable(fault_pin_out) && $stable(locked_out); endproperty
   a_frz: assert property (p_frz) else $error("moved frozen");
   property p_rst; disable iff (1'b0) !nrst_in [*3] |->
      fault_pin_out == SSE_OUT_RST && !locked_out; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
   property p_clr; $fell(reg_stale_out) |-> $past(svc) || $past(svc, 2);
   endproperty
   a_clr: assert property (p_clr) else $error("stale cleared");
   property p_rose; $rose(locked_out) |-> $past(lock_in) && $past(clk_en_in);
   endproperty
   a_rose: assert property (p_rose) else $error("locked alone");
endmodule // sse_engine_asserts
bind sse_engine sse_engine_asserts i_chk (.core_clk_in, .nrst_in, .clk_en_in,
   .in_wr_in, .cfg_wr_in, .lock_in, .unlock_in, .unlock_key_in,
   .fault_pin_out, .fault_report_out, .reg_stale_out, .locked_out);
`default_nettype wire

/* File: verification/safe_state_engine_test.sv */
// self-checking bench for the safe state engine
// assumes sse_engine, its checker and sse_fault_mon compiled before it
`timescale 1ns/1ps
`default_nettype none
module safe_state_engine_test;
   import sse_pkg::*;
   // entries differ wherever the match bit alone changes
   localparam logic [15:0] LUT      = 16'h6C93;
   localparam logic [8:0]  ROWS [4] = '{9'h15A, 9'h0A5, 9'h15A, 9'h000};
   localparam int          IDX_M    = 1 << SSE_IDX_MATCH;
   logic [15:0] cfg_timeout_in = 16'h0006;
   logic [15:0] cfg_lut_in, unlock_key_in = 16'h0000;
   logic [7:0]  pin_in = 8'h00, in_wdata_in, cfg_ref_in, cfg_pin_watch_in;
   logic        core_clk_in = 1'b0, nrst_in = 1'b0, clk_en_in = 1'b1;
   logic        in_wr_in = 1'b0, cfg_wr_in = 1'b0, cfg_src_reg_in;
   logic        lock_in = 1'b0, unlock_in = 1'b0;
   logic [1:0]  fault_pin_out, fault_report_out, mon;
   logic        match_out, reg_stale_out, pin_stale_out, locked_out;
   int          err_total = 0;
   int          cmp_count = 0;
   sse_engine i_dut (.core_clk_in, .nrst_in, .clk_en_in, .pin_in, .in_wr_in,
      .in_wdata_in, .cfg_wr_in, .cfg_src_reg_in, .cfg_ref_in, .cfg_lut_in,
      .cfg_pin_watch_in, .cfg_timeout_in, .lock_in, .unlock_in, .unlock_key_in,
      .fault_pin_out, .fault_report_out, .match_out, .reg_stale_out,
      .pin_stale_out, .locked_out);
   sse_fault_mon i_mon (.clk_in(core_clk_in), .nrst_in,
      .fault_in(fault_pin_out), .latched_out(mon));
   initial forever #12.5 core_clk_in = ~core_clk_in;
   function automatic logic [1:0] ent(input int k);
      return LUT[2*k +: 2];
   endfunction
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #2;
   endtask
   task automatic wr(input logic [7:0] d);
      in_wdata_in = d;
      in_wr_in = 1'b1;
      tick(1);
      in_wr_in = 1'b0;
   endtask
   task automatic cfg(input logic s, input logic [7:0] r, w,
                      input logic [15:0] l);
      cfg_src_reg_in   = s;
      cfg_ref_in       = r;
      cfg_pin_watch_in = w;
      cfg_lut_in       = l;
      cfg_wr_in = 1'b1;
      tick(1);
      cfg_wr_in = 1'b0;
   endtask
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #250000;
      err_total++;
      conclude();
   end
   initial begin
      tick(1);
      cfg(1'b1, 8'h5A, 8'h00, LUT);
      tick(8);
      chk(fault_pin_out, SSE_OUT_RST);
      chk({1'b0, locked_out}, 2'h0);
      nrst_in = 1'b1;
      tick(3);
      $display("test start done");
      cfg(1'b1, 8'h5A, 8'h00, LUT);
      for (int i = 0; i < 4; i++) begin
         wr(ROWS[i][7:0]);
         tick(3);
         chk({1'b0, match_out}, {1'b0, ROWS[i][8]});
         chk(fault_pin_out, ent(ROWS[i][8] ? 4 : 0));
         chk(fault_report_out, ent(ROWS[i][8] ? 4 : 0));
      end
      chk(mon, 2'h3);
      $display("test table done");
      clk_en_in = 1'b0;
      tick(4);
      // a running timer would have expired by now
      chk({reg_stale_out, pin_stale_out}, 2'h0);
      clk_en_in = 1'b1;
      tick(10);
      chk({reg_stale_out, pin_stale_out}, 2'h2);
      chk(fault_pin_out, ent(2));
      wr(8'h5A);
      tick(3);
      chk({reg_stale_out, pin_stale_out}, 2'h0);
      chk(fault_pin_out, ent(4));
      $display("test stale done");
      // lock and service in one cycle so the register dog stays quiet
      lock_in = 1'b1;
      wr(8'h5A);
      lock_in = 1'b0;
      cfg(1'b1, 8'h00, 8'h00, 16'hFFFF);
      tick(2);
      chk(fault_pin_out, ent(4));
      unlock_in = 1'b1;
      tick(1);
      chk({1'b0, locked_out}, 2'h1);
      unlock_key_in = SSE_UNLOCK_KEY;
      tick(1);
      unlock_in = 1'b0;
      chk({1'b0, locked_out}, 2'h0);
      $display("test lock done");
      cfg(1'b0, 8'h00, 8'h01, LUT);
      tick(10);
      chk({1'b0, pin_stale_out}, 2'h1);
      pin_in = 8'h01;
      tick(3);
      chk({pin_stale_out, match_out}, 2'h0);
      chk(fault_report_out, ent(0));
      $display("test pins done");
      lock_in = 1'b1;
      tick(1);
      lock_in = 1'b0;
      chk({1'b0, locked_out}, 2'h1);
      // reset in mid-run must reopen the lock and restore the table
      nrst_in = 1'b0;
      pin_in = 8'h00;
      tick(3);
      chk(fault_pin_out, SSE_OUT_RST);
      chk({1'b0, locked_out}, 2'h0);
      nrst_in = 1'b1;
      tick(4);
      chk(fault_pin_out, SSE_LUT_RST[2*IDX_M +: 2]);
      chk({1'b0, locked_out}, 2'h0);
      $display("test reset done");
      conclude();
   end
endmodule // safe_state_engine_test
`default_nettype wire
